//--- bench/ocd_console_tb_top.sv
`timescale 1ns/1ps
module ocd_console_tb_top;
  import ocd_pkg::*;
  logic sys_clk, resetn, irq_pending, power_down, addressing_error_lamp;
  ocd_core_s core;
  ocd_data_s dpath;
  ocd_panel_s want, panel;
  ocd_req_s req;
  logic [ADDR_W-1:0] bus_addr, addr_display;
  logic [LAMP_N-1:0] state_lamps;
  logic [DATA_W-1:0] data_display;
  int err_total = 0, check_count = 0, cycles = 0;
  // Expected data view per data knob position
  logic [DATA_W-1:0] dview [4] = '{16'h1111, 16'h2222, 16'h3344, 16'h5555};
  ////////////////////////////////////////////////////////////
  ocd_operator ocd_operator_i (.sys_clk(sys_clk), .want(want), .panel(panel));
  ocd_console ocd_console_i (.sys_clk(sys_clk), .resetn(resetn), .core(core), .dpath(dpath),
    .irq_pending(irq_pending), .power_down(power_down), .panel(panel), .req(req),
    .bus_addr(bus_addr), .state_lamps(state_lamps), .addr_display(addr_display),
    .data_display(data_display), .addressing_error_lamp(addressing_error_lamp));
  // 50 MHz
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Settle past the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Button held two edges; returns just after the edge the console acts on it
  task automatic press(input logic [1:0] k, input logic [17:0] s);
    @(posedge sys_clk);
    want.key <= k;
    want.swr <= s;
    want.load_address_switch <= 1'b1;
    tick(1);
    @(posedge sys_clk);
    want.load_address_switch <= 1'b0;
    tick(0);
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Hang guard, well above the roughly 130 cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    core = '0;
    dpath = {16'h1111, 16'h2222, 8'h33, 8'h44, 16'h5555};
    {irq_pending, power_down} = 2'h0;
    want = '0;
    repeat (6) @(posedge sys_clk);
    chk(18'(state_lamps), 18'h0);
    resetn <= 1'b1;
    // Walk the modes, mode 2 reserved
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      core.mode <= 2'(i);
      {core.running, core.dspace_ref, core.bus_owner} <= {i[0], i[0], i[1]};
      {core.in_wait, core.halted, core.wait_for_bus} <= {i == 2, i == 1, i != 1};
      tick(2);
      chk(18'(state_lamps), 18'({i[0], i == 0 || i == 2, i == 1, i == 3,
        i[1] || i == 1, i == 0, i[0] || i == 2}));
    end
    press(KEY_POWER, 18'h1ABCD);
    chk(bus_addr, 18'h1ABCD);
    chk(addr_display, 18'h1ABCD);
    tick(1);
    chk(addr_display, 18'h1ABCD);
    // Lock: load refused, switch register still passes, error not cleared
    @(posedge sys_clk);
    core.addr_error <= 1'b1;
    @(posedge sys_clk);
    core.addr_error <= 1'b0;
    press(KEY_LOCK, 18'h25432);
    chk(bus_addr, 18'h1ABCD);
    chk(req.swr, 18'h25432);
    chk(18'(addressing_error_lamp), 18'h1);
    press(KEY_POWER, 18'h25432);
    chk(18'(addressing_error_lamp), 18'h0);
    // Every knob position: translation off in top 8K, on, then off below top 8K
    for (int c = 0; c < 3; c++) begin
      for (int s = 0; s < 8; s++) begin
        @(posedge sys_clk);
        core.mmu_on <= (c == 1);
        core.paddr <= (c == 2) ? 18'h1E123 : 18'h3E123;
        core.vaddr <= 16'h4567;
        want.asel <= 3'(s);
        want.dsel <= 2'(s + 3);
        tick(3);
        chk(addr_display, s == 6 ? core.paddr : {s == 7 ? 2'h2 : (c == 0 ? 2'h3 : 2'h0),
          c == 1 ? 16'h4567 : 16'hE123});
        chk(18'(data_display), 18'(dview[2'(s + 3)]));
      end
    end
    chk(18'(data_display), 18'h3344);
    @(posedge sys_clk);
    {core.in_wait, irq_pending} <= 2'h3;
    tick(1);
    chk(18'(req.wake), 18'h1);
    results();
  end
endmodule
bind ocd_console ocd_props ocd_props_i (.sys_clk(sys_clk), .resetn(resetn), .core(core),
  .dpath(dpath), .irq_pending(irq_pending), .power_down(power_down), .panel(panel),
  .req(req), .bus_addr(bus_addr), .state_lamps(state_lamps), .addr_display(addr_display),
  .data_display(data_display), .addressing_error_lamp(addressing_error_lamp));

//--- bench/ocd_operator.sv
`timescale 1ns/1ps
module ocd_operator
  import ocd_pkg::*;
(
  input wire logic sys_clk,
  input wire ocd_pkg::ocd_panel_s want,
  output ocd_pkg::ocd_panel_s panel
);
  logic held_r;
  ocd_pkg::ocd_panel_s panel_nxt;
  // A held load button gives one pulse; a long press never repeats
  always_comb begin
    panel_nxt = want;
    panel_nxt.load_address_switch = want.load_address_switch & ~held_r;
  end
  // Switches reach the console one edge after the operator moves them
  always_ff @(posedge sys_clk) begin
    held_r <= want.load_address_switch;
    panel <= panel_nxt;
  end
endmodule

//--- bench/ocd_props.sv
`timescale 1ns/1ps
module ocd_props
  import ocd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire ocd_pkg::ocd_core_s core,
  input wire ocd_pkg::ocd_data_s dpath,
  input wire logic irq_pending,
  input wire logic power_down,
  input wire ocd_pkg::ocd_panel_s panel,
  input wire ocd_pkg::ocd_req_s req,
  input wire logic [ocd_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [ocd_pkg::LAMP_N-1:0] state_lamps,
  input wire logic [ocd_pkg::ADDR_W-1:0] addr_display,
  input wire logic [ocd_pkg::DATA_W-1:0] data_display,
  input wire logic addressing_error_lamp
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Accepted load only; lock must not clear anything
  wire ld = panel.load_address_switch && panel.key == KEY_POWER;
  ////////////////////////////////////////////////////////////
  // Lamps lag the core by one edge; first edge after reset skipped
  property p_run;
    $past(resetn) |-> state_lamps[LAMP_RUN] == $past(core.running | core.in_wait);
  endproperty
  a_run: assert property (p_run) else $error("run lamp");
  // Pause only while the core waits for the bus it does not hold
  property p_pause;
    $past(resetn) |-> state_lamps[LAMP_PAUSE] == $past(core.wait_for_bus & !core.bus_owner);
  endproperty
  a_pause: assert property (p_pause) else $error("pause lamp");
  property p_master;
    $past(resetn) |-> state_lamps[LAMP_MASTER] == $past(core.bus_owner | core.halted);
  endproperty
  a_master: assert property (p_master) else $error("master lamp");
  property p_data;
    $past(resetn) |-> state_lamps[LAMP_DATA] == $past(core.dspace_ref);
  endproperty
  a_data: assert property (p_data) else $error("data lamp");
  property p_mode; $past(resetn) |-> $onehot(state_lamps[LAMP_KERNEL:LAMP_USER]); endproperty
  a_mode: assert property (p_mode) else $error("mode lamps");
  property p_wake; req.wake == (core.in_wait && (irq_pending || power_down ||
    (panel.key == KEY_POWER && (panel.cont || panel.start || panel.halt_sw)))); endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_lock;
    panel.key != KEY_POWER |-> !req.load_address && !req.cont && req.swr == panel.swr;
  endproperty
  a_lock: assert property (p_lock) else $error("lockout");
  property p_load;
    ld && !core.addr_error |=> bus_addr == $past(panel.swr) && !addressing_error_lamp;
  endproperty
  a_load: assert property (p_load) else $error("load address");
  property p_err; core.addr_error |=> addressing_error_lamp; endproperty
  a_err: assert property (p_err) else $error("error set");
  property p_hold; addressing_error_lamp && !ld |=> addressing_error_lamp; endproperty
  a_hold: assert property (p_hold) else $error("error hold");
  property p_micro;
    panel.dsel == DSEL_MICRO |=> data_display == $past({dpath.float_uaddr, dpath.cpu_uaddr});
  endproperty
  a_micro: assert property (p_micro) else $error("micro view");
endmodule

//--- logic/ocd_console.sv
`timescale 1ns/1ps
// Behaviour
// - Key in lock: ignore all controls except the switch register.
// - Key at power: every console control is accepted and acted upon.
// - Run lamp lit while executing, including idling in wait.
// - Wait resumes on interrupt, console intervention or power-down.
// - Pause lamp lit while waiting to regain bus mastership mid-instruction.
// - Master lamp lit while owning the bus or halted from console.
// - Exactly one of user, supervisor, kernel lamps lit per current mode.
// - Data lamp lit when last reference was to data space.
// - Seven state lamps: run, pause, master, user, supervisor, kernel, data.
// - Address display 18 bits, data display 16 bits.
// - Operator switch register is 18 bits.
// - Virtual positions show 16-bit reference; bits 17..16 only for top 8K.
// - Program-physical position shows full 18-bit physical address.
// - Console-physical: low 16 bits reference, upper two from last load-address.
// - Addressing-error lamp lights on any invalid reference.
// - Data display follows knob; micro position packs float and cpu addresses.
// - Load-address copies switch register to bus address and display.
// - Addressing-error lamp holds until a new load-address clears it.
module ocd_console
  import ocd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire ocd_pkg::ocd_core_s core,
  input wire ocd_pkg::ocd_data_s dpath,
  input wire logic irq_pending,
  input wire logic power_down,
  input wire ocd_pkg::ocd_panel_s panel,
  output ocd_pkg::ocd_req_s req,
  output logic [ocd_pkg::ADDR_W-1:0] bus_addr,
  output logic [ocd_pkg::LAMP_N-1:0] state_lamps,
  output logic [ocd_pkg::ADDR_W-1:0] addr_display,
  output logic [ocd_pkg::DATA_W-1:0] data_display,
  output logic addressing_error_lamp
);
  import ocd_pkg::*;

  typedef struct packed {
    logic [LAMP_N-1:0] lamps;
    logic [ADDR_W-1:0] adisp;
    logic [DATA_W-1:0] ddisp;
    logic [ADDR_W-1:0] bus_addr;
    logic [1:0] swr_hi;
    logic shown_load;
  } ocd_state_s;

  ocd_state_s st_r;
  ocd_state_s st_nxt;
  logic controls_ok;
  logic load_go;
  logic err_flag;
  logic [ADDR_W-1:0] ref_16;

  ////////////////////////////////////////////////////////////////////
  // Key switch gating
  // Only the power position passes controls; lock keeps switch register live
  assign controls_ok = (panel.key == KEY_POWER);
  assign load_go = controls_ok && panel.load_address_switch;

  // Request outputs to the core; switch register always passes through
  always_comb begin
    req = '0;
    req.swr = panel.swr;
    if (controls_ok) begin
      req.load_address = panel.load_address_switch;
      req.exam = panel.exam;
      req.cont = panel.cont;
      req.halt_req = panel.halt_sw;
      req.sbus = panel.sbus_sw;
      req.start = panel.start;
      req.dep = panel.dep;
      req.reg_exam = panel.reg_exam;
      req.reg_dep = panel.reg_dep;
    end
    // Any of these three pull the core out of a wait
    req.wake = core.in_wait && (irq_pending || power_down ||
               (controls_ok && (panel.cont || panel.start || panel.halt_sw)));
  end

  ////////////////////////////////////////////////////////////////////
  // Addressing-error lamp, sticky until a new load-address
  ocd_sticky u_err (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .set(core.addr_error),
    .clr(load_go),
    .flag(err_flag)
  );

  ////////////////////////////////////////////////////////////////////
  // 16-bit reference with bits 17..16 lit only for the device page
  always_comb begin
    ref_16 = {2'h0, core.vaddr};
    if (core.mmu_on) begin
      ref_16 = {2'h0, core.vaddr};
    end else begin
      ref_16 = {2'h0, core.paddr[VADDR_W-1:0]};
      if (core.paddr[ADDR_W-1:IO_PAGE_LSB] == IO_PAGE_TAG) begin
        ref_16[ADDR_W-1:VADDR_W] = core.paddr[ADDR_W-1:VADDR_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Next-state for lamps and displays
  always_comb begin
    st_nxt = st_r;
    st_nxt.shown_load = 1'b0;
    // State lamps
    st_nxt.lamps[LAMP_RUN] = core.running || core.in_wait;
    st_nxt.lamps[LAMP_PAUSE] = core.wait_for_bus && !core.bus_owner;
    st_nxt.lamps[LAMP_MASTER] = core.bus_owner || core.halted;
    st_nxt.lamps[LAMP_USER] = (core.mode == MODE_USER);
    st_nxt.lamps[LAMP_SUPER] = (core.mode == MODE_SUPER);
    // Reserved mode code falls back to kernel so one lamp is always lit
    st_nxt.lamps[LAMP_KERNEL] = (core.mode != MODE_USER) &&
                                (core.mode != MODE_SUPER);
    st_nxt.lamps[LAMP_DATA] = core.dspace_ref;
    // Address display by knob
    case (panel.asel)
      ASEL_PROG_PHYS: st_nxt.adisp = core.paddr;
      ASEL_CONS_PHYS: st_nxt.adisp = {st_r.swr_hi, ref_16[VADDR_W-1:0]};
      default: st_nxt.adisp = ref_16;
    endcase
    // Load-address: latch switch register, show it for two refreshes
    if (load_go) begin
      st_nxt.bus_addr = panel.swr;
      st_nxt.swr_hi = panel.swr[ADDR_W-1:VADDR_W];
      st_nxt.adisp = panel.swr;
      st_nxt.shown_load = 1'b1;
    end else if (st_r.shown_load) begin
      st_nxt.adisp = st_r.adisp; // Hold the loaded value one extra cycle
    end
    // Data display by knob
    case (panel.dsel)
      DSEL_DATA_PATHS: st_nxt.ddisp = dpath.alu_out;
      DSEL_BUS_REG: st_nxt.ddisp = dpath.bus_data;
      DSEL_MICRO: st_nxt.ddisp = {dpath.float_uaddr, dpath.cpu_uaddr};
      DSEL_DISP_REG: st_nxt.ddisp = dpath.disp_reg;
      default: st_nxt.ddisp = dpath.alu_out;
    endcase
  end

  // Register all display state; dark after reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign state_lamps = st_r.lamps;
  assign addr_display = st_r.adisp;
  assign data_display = st_r.ddisp;
  assign bus_addr = st_r.bus_addr;
  assign addressing_error_lamp = err_flag;
endmodule

//--- logic/ocd_pkg.sv
package ocd_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int SWR_W = 18;
  localparam int VADDR_W = 16;
  localparam int LAMP_N = 7;
  // Top 8K of the 256K space (248K-256K): bits 17..13 all ones
  localparam logic [4:0] IO_PAGE_TAG = 5'h1F;
  localparam int IO_PAGE_LSB = 13;
  // Key switch positions
  localparam logic [1:0] KEY_OFF = 2'h0;
  localparam logic [1:0] KEY_POWER = 2'h1;
  localparam logic [1:0] KEY_LOCK = 2'h2;
  // Address display knob positions
  localparam logic [2:0] ASEL_USER_I = 3'h0;
  localparam logic [2:0] ASEL_USER_D = 3'h1;
  localparam logic [2:0] ASEL_SUPER_I = 3'h2;
  localparam logic [2:0] ASEL_SUPER_D = 3'h3;
  localparam logic [2:0] ASEL_KERNEL_I = 3'h4;
  localparam logic [2:0] ASEL_KERNEL_D = 3'h5;
  localparam logic [2:0] ASEL_PROG_PHYS = 3'h6;
  localparam logic [2:0] ASEL_CONS_PHYS = 3'h7;
  // Data display knob positions
  localparam logic [1:0] DSEL_DATA_PATHS = 2'h0;
  localparam logic [1:0] DSEL_BUS_REG = 2'h1;
  localparam logic [1:0] DSEL_MICRO = 2'h2;
  localparam logic [1:0] DSEL_DISP_REG = 2'h3;
  // Execution mode encoding from the core
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam logic [1:0] MODE_SUPER = 2'h1;
  localparam logic [1:0] MODE_USER = 2'h3;
  // Lamp bit positions
  localparam int LAMP_RUN = 0;
  localparam int LAMP_PAUSE = 1;
  localparam int LAMP_MASTER = 2;
  localparam int LAMP_USER = 3;
  localparam int LAMP_SUPER = 4;
  localparam int LAMP_KERNEL = 5;
  localparam int LAMP_DATA = 6;
  localparam logic [LAMP_N-1:0] LAMPS_RESET = 7'h00;

  // Core state seen by the console
  typedef struct packed {
    logic running;
    logic in_wait;
    logic wait_for_bus;
    logic bus_owner;
    logic halted;
    logic [1:0] mode;
    logic dspace_ref;
    logic mmu_on;
    logic [VADDR_W-1:0] vaddr;
    logic [ADDR_W-1:0] paddr;
    logic addr_error;
  } ocd_core_s;

  // Datapath words for the data display
  typedef struct packed {
    logic [DATA_W-1:0] alu_out;
    logic [DATA_W-1:0] bus_data;
    logic [7:0] float_uaddr;
    logic [7:0] cpu_uaddr;
    logic [DATA_W-1:0] disp_reg;
  } ocd_data_s;

  // Operator switches (momentary switches are one-cycle pulses)
  typedef struct packed {
    logic [1:0] key;
    logic [SWR_W-1:0] swr;
    logic load_address_switch;
    logic exam;
    logic cont;
    logic halt_sw;
    logic sbus_sw;
    logic start;
    logic dep;
    logic reg_exam;
    logic reg_dep;
    logic [2:0] asel;
    logic [1:0] dsel;
  } ocd_panel_s;

  // Console requests passed to the core, gated by the key switch except swr and the interrupt and power-down wake
  typedef struct packed {
    logic load_address;
    logic exam;
    logic cont;
    logic halt_req;
    logic sbus;
    logic start;
    logic dep;
    logic reg_exam;
    logic reg_dep;
    logic wake;
    logic [SWR_W-1:0] swr;
  } ocd_req_s;
endpackage

//--- logic/ocd_sticky.sv
`timescale 1ns/1ps
// Sticky flag; set wins over clear in the same cycle
module ocd_sticky (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic set,
  input wire logic clr,
  output logic flag
);
  typedef struct packed {
    logic flag;
  } ocd_sticky_s;
  ocd_sticky_s st_r;
  ocd_sticky_s st_nxt;

  // Next-state
  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt.flag = 1'b0;
    end
    if (set) begin
      st_nxt.flag = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag;
endmodule
